// >>> shared/adc_seq_pkg.sv
// Purpose: shared constants and types of the converter serial sequencer
// Assumes: core clock of 10 ns
// Notes:   command byte layout is msb first, start bit at the top
package adc_seq_pkg;
    localparam int CMD_W        = 8;
    localparam int RES_W        = 16;
    localparam int START_POS    = 7;
    localparam int RANGE_POS    = 6;
    localparam int CLKSEL_POS   = 5;
    // falling edges after the start bit; TAIL_BITS counts on from the msb edge
    localparam int STRB_SHORT   = 7;
    localparam int STRB_LONG    = 15;
    localparam int MSB_SHORT    = 8;
    localparam int MSB_LONG     = 16;
    localparam int TAIL_BITS    = 15;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_MAX_NS   = 7000;
    localparam int CONV_CYCLES   = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int CAL_CYCLES    = 80000;
    // reset values
    localparam logic [2:0] GP_RST     = 3'h0;
    localparam logic       RANGE_RST  = 1'h0;
    localparam logic       CLKSEL_RST = 1'h1;

    typedef enum logic [1:0] {OP_SHORT, OP_CAL, OP_PD, OP_LONG} op_e;

    // low seven bits of the command byte
    typedef struct packed {
        logic       range_select;
        logic       conv_clock_select;
        op_e        op;
        logic [2:0] gp;
    } cmd_s;
endpackage

// >>> rtl/adc_serial_control_sequencer.sv
// Purpose: serial command intake and conversion sequencing of a 16-bit converter
// Assumes: sclk is the link clock; adc_code is steady while it is read
// Notes:   conv_strobe is picked between two flops by clock mode, dout by clock mode and loaded_q
module adc_serial_control_sequencer #(
    parameter int CAL_CYCLES = adc_seq_pkg::CAL_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    input  wire logic        shutdown_n,
    input  wire logic [15:0] adc_code,
    output logic             dout,
    output logic             dout_oe,
    output logic             conv_strobe,
    output logic             conv_strobe_oe,
    output logic             gp_out0,
    output logic             gp_out1,
    output logic             gp_out2,
    output logic             range_select,
    output logic             conv_clock_select,
    output logic             sleep
);
    localparam int CONV_LIM = adc_seq_pkg::CONV_CYCLES + 1;
    localparam int CNT_W    = $clog2(CAL_CYCLES + 1);

    if (CAL_CYCLES < adc_seq_pkg::CONV_CYCLES)
        $error("CAL_CYCLES must not be below the conversion time");

    // ------------------------------------------------------------
    // link side: synchronisers on sclk
    // ------------------------------------------------------------
    logic rs1_q, rs2_q, sd1_q, sd2_q;
    logic ra1_q, ra2_q, ra3_q, dn1_q, dn2_q, dn3_q;
    logic rearm_tgl_q, done_tgl_q;

    always_ff @(posedge sclk)
    begin
        rs1_q <= rst_n;
        rs2_q <= rs1_q;
        sd1_q <= shutdown_n;
        sd2_q <= sd1_q;
        ra1_q <= rearm_tgl_q;
        ra2_q <= ra1_q;
        ra3_q <= cs_n ? ra3_q : ra2_q;
        dn1_q <= done_tgl_q;
        dn2_q <= dn1_q;
        dn3_q <= dn2_q;
    end

    logic s_rst, rearm_ev, done_ev;
    assign s_rst    = ~rs2_q;
    assign rearm_ev = ra2_q ^ ra3_q;
    assign done_ev  = dn2_q ^ dn3_q;

    // ------------------------------------------------------------
    // link side: command intake on rising sclk
    // ------------------------------------------------------------
    typedef enum logic [1:0] {L_HUNT, L_RECV, L_BUSY} link_e;
    link_e      st_q;
    logic [6:0] sh_q;
    logic [7:0] cmd_q;
    logic [2:0] bcnt_q;
    logic       run_q, start_tgl_q, req_tgl_q, int_mode_q, int_rdy_q, end_q;
    logic [7:0] byte_d;
    assign byte_d = {sh_q, din};

    always_ff @(posedge sclk)
    begin
        if (s_rst)
        begin
            st_q        <= L_HUNT;
            sh_q        <= 7'h00;
            cmd_q       <= 8'h00;
            bcnt_q      <= 3'h0;
            run_q       <= 1'b0;
            start_tgl_q <= 1'b0;
            req_tgl_q   <= 1'b0;
            int_mode_q  <= adc_seq_pkg::CLKSEL_RST;
            int_rdy_q   <= 1'b0;
        end
        else if (!sd2_q)
        begin
            st_q  <= L_HUNT;
            run_q <= 1'b0;
        end
        else if (!cs_n)
        begin
            if (done_ev)
                int_rdy_q <= 1'b1;
            if (run_q && ((int_mode_q && done_ev) || (!int_mode_q && end_q)))
            begin
                run_q <= 1'b0;
                if (st_q == L_BUSY)
                    st_q <= L_HUNT;
            end
            else if (rearm_ev && st_q == L_BUSY)
                st_q <= L_HUNT;
            unique case (st_q)
                L_HUNT:
                begin
                    if (din)
                    begin
                        st_q        <= L_RECV;
                        sh_q        <= 7'h01;
                        bcnt_q      <= 3'h1;
                        run_q       <= 1'b1;
                        int_rdy_q   <= 1'b0;
                        start_tgl_q <= ~start_tgl_q;
                    end
                end
                L_RECV:
                begin
                    // last bit not shifted: fall logic keeps start-aligned fields
                    if (bcnt_q != 3'h7)
                        sh_q <= byte_d[6:0];
                    bcnt_q <= bcnt_q + 3'h1;
                    if (bcnt_q == 3'h2)
                        int_mode_q <= din;
                    if (bcnt_q == 3'h7)
                    begin
                        cmd_q     <= byte_d;
                        req_tgl_q <= ~req_tgl_q;
                        st_q      <= L_BUSY;
                        if (adc_seq_pkg::op_e'(byte_d[4:3]) == adc_seq_pkg::OP_PD)
                        begin
                            st_q  <= L_HUNT;
                            run_q <= 1'b0;
                        end
                    end
                end
                L_BUSY:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // link side: falling sclk, external conversion and readout
    // ------------------------------------------------------------
    logic [4:0]  fcnt_q, nf;
    logic [15:0] osh_q, store_q, ext_code;
    logic        seen_q, ext_strb_q, loaded_q, ext_conv;
    logic [4:0]  strb_at, msb_at;
    adc_seq_pkg::op_e op_now;

    assign op_now   = adc_seq_pkg::op_e'(sh_q[3:2]);
    assign ext_conv = !sh_q[4] && (op_now == adc_seq_pkg::OP_SHORT
                      || op_now == adc_seq_pkg::OP_LONG);
    assign strb_at  = (op_now == adc_seq_pkg::OP_LONG) ?
                      5'(adc_seq_pkg::STRB_LONG) : 5'(adc_seq_pkg::STRB_SHORT);
    assign msb_at   = (op_now == adc_seq_pkg::OP_LONG) ?
                      5'(adc_seq_pkg::MSB_LONG) : 5'(adc_seq_pkg::MSB_SHORT);
    assign nf       = (seen_q != start_tgl_q) ? 5'h01 : fcnt_q + 5'h01;
    assign ext_code = sh_q[5] ? adc_code : {~adc_code[15], adc_code[14:0]};

    always_ff @(negedge sclk)
    begin
        if (s_rst)
        begin
            fcnt_q     <= 5'h00;
            seen_q     <= 1'b0;
            ext_strb_q <= 1'b0;
            osh_q      <= 16'h0000;
            end_q      <= 1'b0;
            loaded_q   <= 1'b0;
        end
        else if (!cs_n)
        begin
            seen_q     <= start_tgl_q;
            ext_strb_q <= 1'b0;
            if (seen_q != start_tgl_q || (run_q && !end_q))
            begin
                fcnt_q     <= nf;
                end_q      <= 1'b0;
                loaded_q   <= !ext_conv && nf > 5'(adc_seq_pkg::CMD_W);
                ext_strb_q <= ext_conv && nf == strb_at;
                if (ext_conv && nf == msb_at)
                    osh_q <= ext_code;
                else if (ext_conv && nf > msb_at)
                    osh_q <= {osh_q[14:0], 1'b0};
                // internal readout: falls after the command shift from storage
                else if (!ext_conv && nf > 5'(adc_seq_pkg::CMD_W))
                    osh_q <= loaded_q ? {osh_q[14:0], 1'b0}
                             : {store_q[14:0], 1'b0};
                end_q <= ext_conv && nf == msb_at + 5'(adc_seq_pkg::TAIL_BITS);
            end
            else if (int_rdy_q && !loaded_q)
            begin
                osh_q    <= {store_q[14:0], 1'b0};
                loaded_q <= 1'b1;
            end
            else
                osh_q <= {osh_q[14:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // core side: synchronisers on clk
    // ------------------------------------------------------------
    logic sa_q, sb_q, rq_a_q, rq_b_q, rq_c_q, cs_a_q, cs_b_q, cs_c_q;

    always_ff @(posedge clk)
    begin
        sa_q   <= shutdown_n;
        sb_q   <= sa_q;
        rq_a_q <= req_tgl_q;
        rq_b_q <= rq_a_q;
        rq_c_q <= rq_b_q;
        cs_a_q <= cs_n;
        cs_b_q <= cs_a_q;
        cs_c_q <= cs_b_q;
    end

    logic req_ev;
    assign req_ev = rq_b_q ^ rq_c_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rearm_tgl_q <= 1'b0;
        else if (cs_b_q && !cs_c_q)
            rearm_tgl_q <= ~rearm_tgl_q;
    end

    // ------------------------------------------------------------
    // core side: latched configuration
    // ------------------------------------------------------------
    adc_seq_pkg::cmd_s cfg;
    logic              pd_q;
    assign cfg = adc_seq_pkg::cmd_s'(cmd_q[6:0]);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            {gp_out2, gp_out1, gp_out0} <= adc_seq_pkg::GP_RST;
            range_select      <= adc_seq_pkg::RANGE_RST;
            conv_clock_select <= adc_seq_pkg::CLKSEL_RST;
            pd_q              <= 1'b0;
        end
        else if (req_ev)
        begin
            {gp_out2, gp_out1, gp_out0} <= cfg.gp;
            range_select      <= cfg.range_select;
            conv_clock_select <= cfg.conv_clock_select;
            pd_q              <= cfg.op == adc_seq_pkg::OP_PD;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sleep <= 1'b0;
        else
            sleep <= !sb_q || pd_q;
    end

    // ------------------------------------------------------------
    // core side: internal conversion and calibration timer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {C_IDLE, C_CONV, C_CAL} core_e;
    core_e            cst_q;
    logic [CNT_W-1:0] cnt_q;
    logic             int_strb_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cst_q      <= C_IDLE;
            cnt_q      <= '0;
            int_strb_q <= 1'b1;
            done_tgl_q <= 1'b0;
            store_q    <= 16'h0000;
        end
        else if (!sb_q)
        begin
            cst_q      <= C_IDLE;
            int_strb_q <= 1'b1;
        end
        else if (req_ev && cfg.op == adc_seq_pkg::OP_CAL)
        begin
            cst_q      <= C_CAL;
            cnt_q      <= CNT_W'(CAL_CYCLES - 1);
            int_strb_q <= 1'b0;
        end
        else if (req_ev && cfg.conv_clock_select && cfg.op != adc_seq_pkg::OP_PD)
        begin
            cst_q      <= C_CONV;
            cnt_q      <= CNT_W'(adc_seq_pkg::CONV_CYCLES - 1);
            int_strb_q <= 1'b0;
        end
        else if (cst_q != C_IDLE)
        begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == '0)
            begin
                if (cst_q == C_CONV)
                    store_q <= range_select ? adc_code
                               : {~adc_code[15], adc_code[14:0]};
                cst_q      <= C_IDLE;
                int_strb_q <= 1'b1;
                done_tgl_q <= ~done_tgl_q;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    assign conv_strobe    = int_mode_q ? int_strb_q : ext_strb_q;
    assign conv_strobe_oe = int_mode_q || !cs_n;
    assign dout           = (int_mode_q && !loaded_q) ?
                            store_q[15] : osh_q[15];
    assign dout_oe        = !cs_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_reset_defaults: assert property (@(posedge clk) !rst_n |=>
        {gp_out2, gp_out1, gp_out0} == 3'h0 && !range_select && conv_clock_select)
        else $error("reset defaults not restored");
    a_shutdown_stop: assert property (@(posedge clk) disable iff (!rst_n)
        !sb_q |=> cst_q == C_IDLE && int_strb_q)
        else $error("shutdown did not stop conversion");
    a_conv_bounded: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cst_q == C_CONV) |-> ##[1:CONV_LIM] cst_q != C_CONV)
        else $error("internal conversion too long");
    a_strobe_low_busy: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(int_strb_q) |-> $past(cst_q) != C_IDLE && cst_q == C_IDLE)
        else $error("strobe rose without completion");
    a_gp_hold_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        (!sb_q && !req_ev) |=> $stable({gp_out2, gp_out1, gp_out0}))
        else $error("gp outputs moved in shutdown");
    a_ext_strobe_one: assert property (@(negedge sclk) disable iff (s_rst)
        ext_strb_q |=> !ext_strb_q)
        else $error("external strobe wider than one clock");
    a_ext_strobe_pos: assert property (@(negedge sclk) disable iff (s_rst)
        $rose(ext_strb_q) |-> fcnt_q == 5'h07 || fcnt_q == 5'h0F)
        else $error("external strobe at wrong edge");
    a_zero_ignored: assert property (@(posedge sclk) disable iff (s_rst || !sd2_q)
        (st_q == L_HUNT && !din && !cs_n) |=> st_q == L_HUNT && $stable(start_tgl_q))
        else $error("zero bit left hunt");
    a_cs_gate: assert property (@(posedge sclk) disable iff (s_rst || !sd2_q)
        cs_n |=> $stable(st_q) && $stable(cmd_q))
        else $error("intake moved while cs high");
    a_byte_latch: assert property (@(posedge sclk) disable iff (s_rst || !sd2_q)
        (st_q == L_RECV && bcnt_q == 3'h7 && !cs_n) |=> cmd_q[7] && st_q != L_RECV)
        else $error("command byte not latched");
endmodule

// >>> verif/host_master.sv
// Purpose: host serial master model driving the converter link
// Assumes: sclk rests low outside frames, 32 ns period
// Notes:   din shows the inverse of its last bit while deselected
module host_master (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic conv_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // n bits msb first; dout and strobe taken at each rise
    task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx,
                        output logic [63:0] st);
        rx = '0;
        st = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            din = tx[i];
            #16;
            sclk = 1'b1;
            rx = {rx[62:0], dout};
            st = {st[62:0], conv_strobe};
            #16;
            sclk = 1'b0;
        end
    endtask

    task automatic select_dev(input logic on);
        #40;
        cs_n = ~on;
        if (!on)
            din = ~din;
        #40;
    endtask

    task automatic idle_clocks(input int n);
        repeat (n)
        begin
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
    endtask
endmodule

// >>> verif/testbench.sv
// Purpose: self-checking bench of the converter serial sequencer
// Assumes: host model also makes sclk outside frames, through idle_clocks while cs_n is high
// Notes:   calibration length shortened through CAL_CYCLES
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CAL_SIM = 800;

    logic        clk;
    logic        rst_n;
    logic        shutdown_n;
    logic [15:0] adc_code;
    logic        sclk;
    logic        cs_n;
    logic        din;
    logic        dout;
    logic        dout_oe;
    logic        conv_strobe;
    logic        conv_strobe_oe;
    logic        gp_out0;
    logic        gp_out1;
    logic        gp_out2;
    logic        range_select;
    logic        conv_clock_select;
    logic        sleep;
    wire         dout_w;
    wire         strobe_w;
    logic [63:0] rx;
    logic [63:0] st;
    int          n_mismatch;
    int          n_checks;

    assign dout_w   = dout_oe ? dout : 1'bz;
    assign strobe_w = conv_strobe_oe ? conv_strobe : 1'bz;

    adc_serial_control_sequencer #(.CAL_CYCLES(CAL_SIM)) adc_serial_control_sequencer_inst (
        .clk               (clk),
        .rst_n             (rst_n),
        .sclk              (sclk),
        .cs_n              (cs_n),
        .din               (din),
        .shutdown_n        (shutdown_n),
        .adc_code          (adc_code),
        .dout              (dout),
        .dout_oe           (dout_oe),
        .conv_strobe       (conv_strobe),
        .conv_strobe_oe    (conv_strobe_oe),
        .gp_out0           (gp_out0),
        .gp_out1           (gp_out1),
        .gp_out2           (gp_out2),
        .range_select      (range_select),
        .conv_clock_select (conv_clock_select),
        .sleep             (sleep)
    );

    host_master host_master_inst (
        .sclk        (sclk),
        .cs_n        (cs_n),
        .din         (din),
        .dout        (dout_w),
        .conv_strobe (strobe_w)
    );

    always #5 clk = ~clk;

    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [15:0] exp_code(input logic uni, input logic [15:0] c);
        return uni ? c : {~c[15], c[14:0]};
    endfunction

    task automatic wait_strobe(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (conv_strobe !== lvl && cnt < lim)
        begin
            @(negedge clk);
            cnt++;
        end
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        fork
            repeat (16) @(negedge clk);
            host_master_inst.idle_clocks(6);
        join
        @(negedge clk);
        chk({gp_out2, gp_out1, gp_out0, range_select, conv_clock_select, conv_strobe, sleep},
            32'h6, "reset values");
        rst_n = 1'b1;
        host_master_inst.idle_clocks(4);
        @(negedge clk);
        $display("test reset done");
    endtask

    task automatic run_ext(input logic [7:0] cmd, input int lead, input logic [15:0] code);
        int mpos;
        int n;
        @(negedge clk);
        mpos = (cmd[4:3] == 2'h3) ? adc_seq_pkg::MSB_LONG : adc_seq_pkg::MSB_SHORT;
        n = lead + mpos + 17;
        adc_code = code;
        host_master_inst.select_dev(1'b1);
        host_master_inst.xfer(n, 64'(cmd) << (n - lead - 8), rx, st);
        // msb seen at the rise after fall mpos, one trailing rise follows bit 0
        chk(32'(rx[16:1]), 32'(exp_code(cmd[6], code)), "ext result");
        chk(32'(st & ((64'h1 << (n - lead - 4)) - 1)), 32'(64'h1 << (n - lead - mpos)),
            "ext strobe");
        chk({29'h0, gp_out2, gp_out1, gp_out0}, 32'(cmd[2:0]), "gp");
        chk({30'h0, range_select, conv_clock_select}, 32'(cmd[6:5]), "mode");
        host_master_inst.select_dev(1'b0);
        chk({30'h0, dout_oe, conv_strobe_oe}, 32'h0, "hiz");
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_ext();
        run_ext(8'h87, 0, 16'h4321);
        run_ext(8'hDA, 5, 16'hC35A);
        $display("test external done");
    endtask

    task automatic t_split();
        @(negedge clk);
        adc_code = 16'h0F0F;
        host_master_inst.select_dev(1'b1);
        host_master_inst.xfer(8, 64'h80, rx, st);
        host_master_inst.select_dev(1'b0);
        chk(32'(conv_strobe_oe), 32'h0, "split hiz");
        host_master_inst.idle_clocks(3);
        host_master_inst.select_dev(1'b1);
        host_master_inst.xfer(17, 64'h0, rx, st);
        host_master_inst.select_dev(1'b0);
        chk(32'(rx[16:1]), 32'(exp_code(1'b0, 16'h0F0F)), "split");
        $display("test split done");
    endtask

    task automatic t_abort();
        @(negedge clk);
        host_master_inst.select_dev(1'b1);
        host_master_inst.xfer(12, 64'h820, rx, st);
        host_master_inst.select_dev(1'b0);
        // rearm needs sclk edges to cross: lead with zeros
        run_ext(8'hDF, 3, 16'hBEEF);
        $display("test abort done");
    endtask

    task automatic t_internal();
        int c;
        @(negedge clk);
        adc_code = 16'h8001;
        host_master_inst.select_dev(1'b1);
        host_master_inst.xfer(8, 64'hE5, rx, st);
        host_master_inst.select_dev(1'b0);
        wait_strobe(1'b0, 40, c);
        chk({30'h0, conv_strobe, conv_strobe_oe}, 32'h1, "int start");
        wait_strobe(1'b1, 900, c);
        chk(32'(c <= adc_seq_pkg::CONV_CYCLES), 32'h1, "int length");
        host_master_inst.select_dev(1'b1);
        host_master_inst.xfer(16, 64'h0, rx, st);
        host_master_inst.select_dev(1'b0);
        chk(32'(rx[15:0]), 32'h8001, "int result");
        $display("test internal done");
    endtask

    task automatic t_modes();
        int c;
        @(negedge clk);
        host_master_inst.select_dev(1'b1);
        host_master_inst.xfer(8, 64'hAE, rx, st);
        host_master_inst.select_dev(1'b0);
        wait_strobe(1'b0, 40, c);
        wait_strobe(1'b1, CAL_SIM + 100, c);
        chk(32'(c > CAL_SIM / 2 && c < CAL_SIM + 20), 32'h1, "cal length");
        shutdown_n = 1'b0;
        repeat (6) @(negedge clk);
        chk({28'h0, sleep, gp_out2, gp_out1, gp_out0}, 32'hE, "shutdown");
        shutdown_n = 1'b1;
        repeat (6) @(negedge clk);
        chk(32'(sleep), 32'h0, "wake");
        host_master_inst.select_dev(1'b1);
        host_master_inst.xfer(11, 64'hB3, rx, st);
        host_master_inst.select_dev(1'b0);
        repeat (6) @(negedge clk);
        chk({28'h0, sleep, gp_out2, gp_out1, gp_out0}, 32'hB, "power down");
        $display("test modes done");
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        shutdown_n = 1'b1;
        adc_code = 16'h0000;
        n_mismatch = 0;
        n_checks = 0;
        do_reset();
        t_ext();
        t_split();
        t_abort();
        t_internal();
        t_modes();
        do_reset();
        finish_test();
    end

    initial
    begin
        #500us;
        n_mismatch++;
        finish_test();
    end
endmodule
